// ===== dtt_trigger.v
// trigger front end: event latching, queue evaluation and request submission
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
`include "dtt_defines.vh"
module dtt_trigger #(
  parameter NUM_QCH = 8,
  parameter PSET_W = 9,
  parameter [63:0] SRC_MASK = `DTT_SRC_MASK
) (
  input wire CLK_SYS,
  input wire ARST_N,
  input wire [7:0] ADDR,
  input wire [31:0] WDATA,
  input wire WSTB,
  input wire RSTB,
  output reg [31:0] RDATA,
  input wire [63:0] HW_EVT,
  input wire CMPL_STB,
  input wire [5:0] CMPL_CODE,
  input wire SWTRIG_STB,
  input wire [PSET_W-1:0] SWTRIG_SET,
  input wire LNKTRIG_STB,
  input wire [PSET_W-1:0] LNKTRIG_SET,
  input wire [63:0] PSET_NULL,
  input wire [NUM_QCH-1:0] QSET_NULL,
  output wire TR_VALID,
  input wire TR_READY,
  output wire [5:0] TR_CH,
  output wire TR_QUICK
);

  // source selectors for the winning channel
  localparam SRC_LATCH = 2'h0;
  localparam SRC_SET = 2'h1;
  localparam SRC_CHAIN = 2'h2;
  localparam SRC_QUICK = 2'h3;

  reg [63:0] latch_reg;
  reg [63:0] latch_next;
  reg [63:0] enable_reg;
  reg [63:0] set_reg;
  reg [63:0] set_next;
  reg [63:0] miss_reg;
  reg [63:0] miss_next;
  reg [63:0] chain_reg;
  reg [63:0] chain_next;
  reg [NUM_QCH-1:0] qevt_reg;
  reg [NUM_QCH-1:0] qevt_next;
  reg [NUM_QCH-1:0] qen_reg;
  reg [NUM_QCH-1:0] qmiss_reg;
  reg [NUM_QCH-1:0] qmiss_next;
  reg [PSET_W-1:0] qmap_reg [0:NUM_QCH-1];
  reg tr_valid_reg;
  reg [5:0] tr_ch_reg;
  reg tr_quick_reg;

  // placement of a written word onto the low or high half
  function [63:0] half_mask;
    input hi;
    input [31:0] d;
    begin
      half_mask = hi ? {d, 32'h00000000} : {32'h00000000, d};
    end
  endfunction

  wire wr_latch = WSTB && (ADDR == `DTT_OFS_LATCH_LO || ADDR == `DTT_OFS_LATCH_HI);
  wire wr_enable = WSTB && (ADDR == `DTT_OFS_ENABLE_LO || ADDR == `DTT_OFS_ENABLE_HI);
  wire wr_set = WSTB && (ADDR == `DTT_OFS_SET_LO || ADDR == `DTT_OFS_SET_HI);
  wire wr_miss = WSTB && (ADDR == `DTT_OFS_MISS_LO || ADDR == `DTT_OFS_MISS_HI);
  wire wr_chain = WSTB && (ADDR == `DTT_OFS_CHAIN_LO || ADDR == `DTT_OFS_CHAIN_HI);
  wire wr_qen = WSTB && (ADDR == `DTT_OFS_QEN);
  wire wr_qmiss = WSTB && (ADDR == `DTT_OFS_QMISS);
  wire [63:0] wmask = half_mask(ADDR[2], WDATA);
  wire [63:0] clr_latch_sw = wr_latch ? wmask : 64'h0000000000000000;
  wire [63:0] set_wr = wr_set ? wmask : 64'h0000000000000000;
  wire [63:0] clr_miss_sw = wr_miss ? wmask : 64'h0000000000000000;
  wire [63:0] clr_chain_sw = wr_chain ? wmask : 64'h0000000000000000;
  // channels without a source never latch a hardware event
  wire [63:0] hw_in = HW_EVT & SRC_MASK;
  wire [63:0] chain_in = CMPL_STB ? (64'h0000000000000001 << CMPL_CODE) :
    64'h0000000000000000;

  // quick trigger word match against each channel map
  reg [NUM_QCH-1:0] q_hit;
  integer qi;
  always @* begin
    q_hit = {NUM_QCH{1'b0}};
    for (qi = 0; qi < NUM_QCH; qi = qi + 1) begin
      q_hit[qi] = ((SWTRIG_STB && SWTRIG_SET == qmap_reg[qi]) ||
        (LNKTRIG_STB && LNKTRIG_SET == qmap_reg[qi])) && qen_reg[qi];
    end
  end

  // enabled latch bits queue; manual and chain bits queue unconditionally
  wire [63:0] elig_dma = (latch_reg & enable_reg) | set_reg | chain_reg;
  wire eval_free = !tr_valid_reg; // head is evaluated only when the output slot is empty

  // fixed priority: lowest dma channel first, quick channels after
  reg found;
  reg [5:0] win_ch;
  reg [1:0] win_src;
  reg win_null;
  integer ci;
  always @* begin
    found = 1'b0;
    win_ch = 6'h00;
    win_src = SRC_LATCH;
    win_null = 1'b0;
    for (ci = 63; ci >= 0; ci = ci - 1) begin
      if (elig_dma[ci]) begin
        found = 1'b1;
        win_ch = ci[5:0];
        win_null = PSET_NULL[ci];
        if (latch_reg[ci] && enable_reg[ci])
          win_src = SRC_LATCH;
        else if (set_reg[ci])
          win_src = SRC_SET;
        else
          win_src = SRC_CHAIN;
      end
    end
    if (!found) begin
      for (ci = NUM_QCH - 1; ci >= 0; ci = ci - 1) begin
        if (qevt_reg[ci]) begin
          found = 1'b1;
          win_ch = ci[5:0];
          win_src = SRC_QUICK;
          win_null = QSET_NULL[ci];
        end
      end
    end
  end

  wire eval_go = eval_free && found;
  wire [63:0] win_bit = 64'h0000000000000001 << win_ch;
  wire [NUM_QCH-1:0] win_qbit = {{(NUM_QCH-1){1'b0}}, 1'b1} << win_ch;
  // the served source bit is cleared whether submitted or discarded
  wire [63:0] clr_latch_ev = (eval_go && win_src == SRC_LATCH) ? win_bit :
    64'h0000000000000000;
  wire [63:0] clr_set_ev = (eval_go && win_src == SRC_SET) ? win_bit :
    64'h0000000000000000;
  wire [63:0] clr_chain_ev = (eval_go && win_src == SRC_CHAIN) ? win_bit :
    64'h0000000000000000;
  wire [NUM_QCH-1:0] clr_q_ev = (eval_go && win_src == SRC_QUICK) ? win_qbit :
    {NUM_QCH{1'b0}};
  wire null_dma = eval_go && win_null && win_src != SRC_QUICK;
  wire null_q = eval_go && win_null && win_src == SRC_QUICK;

  // miss sources: a trigger on a bit still pending and not served now, or a null set discarded
  wire [63:0] miss_hw = hw_in & latch_reg & ~clr_latch_ev;
  wire [63:0] miss_set = set_wr & set_reg & ~clr_set_ev;
  wire [63:0] miss_chain = chain_in & chain_reg & ~clr_chain_ev;
  wire [63:0] miss_null = null_dma ? win_bit : 64'h0000000000000000;
  wire [NUM_QCH-1:0] clr_qmiss_sw = wr_qmiss ? WDATA[NUM_QCH-1:0] : {NUM_QCH{1'b0}};
  wire [NUM_QCH-1:0] miss_q_again = q_hit & qevt_reg & ~clr_q_ev;
  wire [NUM_QCH-1:0] miss_q_null = null_q ? win_qbit : {NUM_QCH{1'b0}};

  // event latch next; a new arrival wins over a clear in the same cycle
  always @* begin
    latch_next = (latch_reg & ~clr_latch_ev & ~clr_latch_sw) | hw_in;
  end

  // manual trigger bits; a written zero leaves a bit alone
  always @* begin
    set_next = (set_reg & ~clr_set_ev) | set_wr;
  end

  // chain bits, set by a completion code
  always @* begin
    chain_next = (chain_reg & ~clr_chain_ev & ~clr_chain_sw) | chain_in;
  end

  // quick event bits
  always @* begin
    qevt_next = (qevt_reg & ~clr_q_ev) | q_hit;
  end

  // miss bits; a fresh miss wins over a software clear so none is lost
  always @* begin
    miss_next = (miss_reg & ~clr_miss_sw) | miss_hw | miss_set | miss_chain | miss_null;
  end

  // quick miss bits
  always @* begin
    qmiss_next = (qmiss_reg & ~clr_qmiss_sw) | miss_q_again | miss_q_null;
  end

  // hardware event latch
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N)
      latch_reg <= `DTT_RST_64;
    else
      latch_reg <= latch_next;
  end

  // pending manual triggers
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N)
      set_reg <= `DTT_RST_64;
    else
      set_reg <= set_next;
  end

  // miss flags
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N)
      miss_reg <= `DTT_RST_64;
    else
      miss_reg <= miss_next;
  end

  // pending chain triggers
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N)
      chain_reg <= `DTT_RST_64;
    else
      chain_reg <= chain_next;
  end

  // quick event and quick miss bits
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      qevt_reg <= {NUM_QCH{1'b0}};
      qmiss_reg <= {NUM_QCH{1'b0}};
    end else begin
      qevt_reg <= qevt_next;
      qmiss_reg <= qmiss_next;
    end
  end

  // channel enables, written a half at a time
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N)
      enable_reg <= `DTT_RST_64;
    else if (wr_enable && ADDR[2])
      enable_reg[63:32] <= WDATA;
    else if (wr_enable)
      enable_reg[31:0] <= WDATA;
  end

  // quick channel enables
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N)
      qen_reg <= {NUM_QCH{1'b0}};
    else if (wr_qen)
      qen_reg <= WDATA[NUM_QCH-1:0];
  end

  // quick map address decode, shared by the write and read paths
  reg [NUM_QCH-1:0] qmap_hit;
  integer ai;
  always @* begin
    qmap_hit = {NUM_QCH{1'b0}};
    for (ai = 0; ai < NUM_QCH; ai = ai + 1) begin
      qmap_hit[ai] = (ADDR == `DTT_OFS_QMAP_BASE + ai[7:0] * 8'h04);
    end
  end

  // quick channel map words, one register per channel
  integer mi;
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      for (mi = 0; mi < NUM_QCH; mi = mi + 1)
        qmap_reg[mi] <= {PSET_W{1'b0}};
    end else begin
      for (mi = 0; mi < NUM_QCH; mi = mi + 1) begin
        if (WSTB && qmap_hit[mi])
          qmap_reg[mi] <= WDATA[PSET_W-1:0];
      end
    end
  end

  // a submission loads the slot; a null set is discarded without one
  wire submit = eval_go && !win_null;

  // request valid; set at a submission, dropped at the edge that takes it
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N)
      tr_valid_reg <= 1'b0;
    else if (submit)
      tr_valid_reg <= 1'b1;
    else if (TR_READY)
      tr_valid_reg <= 1'b0;
  end

  // request payload; loaded only with a submission so it stands until taken
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      tr_ch_reg <= 6'h00;
      tr_quick_reg <= 1'b0;
    end else if (submit) begin
      tr_ch_reg <= win_ch;
      tr_quick_reg <= (win_src == SRC_QUICK);
    end
  end

  assign TR_VALID = tr_valid_reg;
  assign TR_CH = tr_ch_reg;
  assign TR_QUICK = tr_quick_reg;

  // read mux; unmapped addresses read zero
  reg [31:0] rd_val;
  integer ri;
  always @* begin
    rd_val = 32'h00000000;
    case (ADDR)
      `DTT_OFS_LATCH_LO: rd_val = latch_reg[31:0];
      `DTT_OFS_LATCH_HI: rd_val = latch_reg[63:32];
      `DTT_OFS_ENABLE_LO: rd_val = enable_reg[31:0];
      `DTT_OFS_ENABLE_HI: rd_val = enable_reg[63:32];
      `DTT_OFS_SET_LO: rd_val = set_reg[31:0];
      `DTT_OFS_SET_HI: rd_val = set_reg[63:32];
      `DTT_OFS_MISS_LO: rd_val = miss_reg[31:0];
      `DTT_OFS_MISS_HI: rd_val = miss_reg[63:32];
      `DTT_OFS_CHAIN_LO: rd_val = chain_reg[31:0];
      `DTT_OFS_CHAIN_HI: rd_val = chain_reg[63:32];
      `DTT_OFS_QEVT: rd_val[NUM_QCH-1:0] = qevt_reg;
      `DTT_OFS_QEN: rd_val[NUM_QCH-1:0] = qen_reg;
      `DTT_OFS_QMISS: rd_val[NUM_QCH-1:0] = qmiss_reg;
      default: begin
        for (ri = 0; ri < NUM_QCH; ri = ri + 1) begin
          if (qmap_hit[ri])
            rd_val[PSET_W-1:0] = qmap_reg[ri];
        end
      end
    endcase
  end

  // read data stands the cycle after the strobe only
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N)
      RDATA <= `DTT_RST_32;
    else if (RSTB)
      RDATA <= rd_val;
    else
      RDATA <= `DTT_RST_32;
  end

endmodule // dtt_trigger

// ===== dtt_defines.vh
// register offsets, reset values and source map for the trigger front end
`ifndef DTT_DEFINES_VH
`define DTT_DEFINES_VH
`define DTT_OFS_LATCH_LO 8'h00
`define DTT_OFS_LATCH_HI 8'h04
`define DTT_OFS_ENABLE_LO 8'h08
`define DTT_OFS_ENABLE_HI 8'h0c
`define DTT_OFS_SET_LO 8'h10
`define DTT_OFS_SET_HI 8'h14
`define DTT_OFS_MISS_LO 8'h18
`define DTT_OFS_MISS_HI 8'h1c
`define DTT_OFS_CHAIN_LO 8'h20
`define DTT_OFS_CHAIN_HI 8'h24
`define DTT_OFS_QEVT 8'h28
`define DTT_OFS_QEN 8'h2c
`define DTT_OFS_QMISS 8'h30
`define DTT_OFS_QMAP_BASE 8'h40
`define DTT_RST_64 64'h0000000000000000
`define DTT_RST_32 32'h00000000
`define DTT_SRC_MASK 64'hffff3107f3fbfe07
`endif

// ===== dtt_trigger_asserts.sv
// port checker for the trigger front end
`timescale 1ns/1ps
`include "dtt_defines.vh"
module dtt_trigger_asserts #(
  parameter NUM_QCH = 8
) (
  input wire CLK_SYS,
  input wire ARST_N,
  input wire [7:0] ADDR,
  input wire [31:0] WDATA,
  input wire WSTB,
  input wire RSTB,
  input wire [31:0] RDATA,
  input wire [63:0] PSET_NULL,
  input wire [NUM_QCH-1:0] QSET_NULL,
  input wire TR_VALID,
  input wire TR_READY,
  input wire [5:0] TR_CH,
  input wire TR_QUICK
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  // read data only in the cycle after a read strobe
  a_rd_idle_zero: assert property (
    !$past(RSTB) |-> RDATA == 32'h0) else $error("read data outside read cycle");
  a_rd_unmapped: assert property (
    RSTB && ADDR == 8'hfc |=> RDATA == 32'h0) else $error("unmapped read not zero");
  a_enable_rw: assert property (
    WSTB && ADDR == `DTT_OFS_ENABLE_LO ##1 !WSTB ##1 RSTB && ADDR == `DTT_OFS_ENABLE_LO
    |=> RDATA == $past(WDATA, 3)) else $error("enable readback wrong");
  // request stands unchanged until taken, then drops
  a_req_hold: assert property (
    TR_VALID && !TR_READY |=> TR_VALID && $stable(TR_CH) && $stable(TR_QUICK))
    else $error("request changed before accept");
  a_req_release: assert property (
    TR_VALID && TR_READY |=> !TR_VALID) else $error("request not released");
  a_reset_quiet: assert property (
    $rose(ARST_N) |-> !TR_VALID && RDATA == 32'h0) else $error("busy after reset");
  // a null set never yields a request
  a_null_dma: assert property (
    $rose(TR_VALID) && !TR_QUICK |-> ($past(PSET_NULL) & (64'h1 << TR_CH)) == 64'h0)
    else $error("request from null set");
  a_null_quick: assert property (
    $rose(TR_VALID) && TR_QUICK |-> TR_CH < NUM_QCH && ($past(QSET_NULL) >> TR_CH) % 2 == 0)
    else $error("bad quick request");
endmodule // dtt_trigger_asserts
bind dtt_trigger dtt_trigger_asserts #(.NUM_QCH(NUM_QCH)) u_chk (.CLK_SYS(CLK_SYS),
  .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA), .WSTB(WSTB), .RSTB(RSTB), .RDATA(RDATA),
  .PSET_NULL(PSET_NULL), .QSET_NULL(QSET_NULL), .TR_VALID(TR_VALID), .TR_READY(TR_READY),
  .TR_CH(TR_CH), .TR_QUICK(TR_QUICK));

// ===== dtt_tc_model.sv
// transfer controller model: takes requests after a set delay
`timescale 1ns/1ps
module dtt_tc_model (
  input wire clk,
  input wire rst_n,
  input wire tr_valid,
  input wire [5:0] tr_ch,
  input wire tr_quick,
  input wire [3:0] delay,
  output reg tr_ready,
  output reg [6:0] last,
  output reg [15:0] count
);
  reg [3:0] wait_reg;
  // ready only after the delay, so slow acceptance keeps the slot busy
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tr_ready <= 1'b0;
      wait_reg <= 4'h0;
      last <= 7'h00;
      count <= 16'h0000;
    end else if (tr_valid && tr_ready) begin
      tr_ready <= 1'b0;
      wait_reg <= 4'h0;
      last <= {tr_quick, tr_ch};
      count <= count + 16'h0001;
    end else if (tr_valid) begin
      if (wait_reg >= delay) tr_ready <= 1'b1;
      else wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule // dtt_tc_model

// ===== dtt_trigger_test.sv
// self-checking bench for the trigger front end
`timescale 1ns/1ps
`include "dtt_defines.vh"
module dtt_trigger_test;
  reg CLK_SYS = 0, ARST_N = 0, WSTB = 0, RSTB = 0, CMPL_STB = 0;
  reg SWTRIG_STB = 0, LNKTRIG_STB = 0;
  reg [7:0] ADDR = 8'h00, QSET_NULL = 8'h00;
  reg [31:0] WDATA = 32'h0;
  reg [63:0] HW_EVT = 64'h0, PSET_NULL = 64'h0;
  reg [5:0] CMPL_CODE = 6'h00;
  reg [8:0] SWTRIG_SET = 9'h000, LNKTRIG_SET = 9'h000;
  reg [3:0] tc_delay = 4'h0;
  wire [31:0] RDATA;
  wire TR_VALID, TR_READY, TR_QUICK;
  wire [5:0] TR_CH;
  wire [6:0] tc_last;
  wire [15:0] tc_count;
  integer bad_count = 0, n_tests = 0, exp_n = 0;
  dtt_trigger uut (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA), .WSTB(WSTB),
    .RSTB(RSTB), .RDATA(RDATA), .HW_EVT(HW_EVT), .CMPL_STB(CMPL_STB), .CMPL_CODE(CMPL_CODE),
    .SWTRIG_STB(SWTRIG_STB), .SWTRIG_SET(SWTRIG_SET), .LNKTRIG_STB(LNKTRIG_STB),
    .LNKTRIG_SET(LNKTRIG_SET), .PSET_NULL(PSET_NULL), .QSET_NULL(QSET_NULL),
    .TR_VALID(TR_VALID), .TR_READY(TR_READY), .TR_CH(TR_CH), .TR_QUICK(TR_QUICK));
  dtt_tc_model tc (.clk(CLK_SYS), .rst_n(ARST_N), .tr_valid(TR_VALID), .tr_ch(TR_CH),
    .tr_quick(TR_QUICK), .delay(tc_delay), .tr_ready(TR_READY), .last(tc_last),
    .count(tc_count));
  always #4 CLK_SYS = ~CLK_SYS;
  task give_verdict;
    begin
      if (bad_count == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    begin
      @(posedge CLK_SYS) begin ADDR <= a; WDATA <= v; WSTB <= 1'b1; end
      @(posedge CLK_SYS) WSTB <= 1'b0;
    end
  endtask
  // read data stands only in the cycle after the strobe
  task rd_chk(input [7:0] a, input [31:0] exp);
    begin
      @(posedge CLK_SYS) begin ADDR <= a; RSTB <= 1'b1; end
      @(posedge CLK_SYS) RSTB <= 1'b0;
      #1 chk(RDATA, exp);
    end
  endtask
  task pulse_hw(input integer ch);
    begin
      @(posedge CLK_SYS) HW_EVT <= 64'h1 << ch;
      @(posedge CLK_SYS) HW_EVT <= 64'h0;
    end
  endtask
  task trig_q(input lnk, input [8:0] s);
    begin
      @(posedge CLK_SYS) begin SWTRIG_SET <= s; LNKTRIG_SET <= s; SWTRIG_STB <= !lnk;
        LNKTRIG_STB <= lnk; end
      @(posedge CLK_SYS) begin SWTRIG_STB <= 1'b0; LNKTRIG_STB <= 1'b0; end
    end
  endtask
  // waits for the next accepted request, bounded
  task tr_chk(input quick, input [5:0] ch);
    integer i;
    begin
      exp_n = exp_n + 1;
      for (i = 0; i < 80 && tc_count < exp_n; i = i + 1) @(posedge CLK_SYS);
      if (tc_count < exp_n) begin
        bad_count = bad_count + 1;
        $display("[ERR] %0t no request", $time);
        give_verdict;
      end else begin
        chk({25'h0, tc_last}, {25'h0, quick, ch});
      end
    end
  endtask
  task s_hw;
    begin
      pulse_hw(0);
      rd_chk(`DTT_OFS_LATCH_LO, 32'h1);
      wr(`DTT_OFS_LATCH_LO, 32'h1);
      rd_chk(`DTT_OFS_LATCH_LO, 32'h0);
      wr(`DTT_OFS_ENABLE_LO, 32'h2);
      rd_chk(`DTT_OFS_ENABLE_LO, 32'h2);
      pulse_hw(1);
      tr_chk(1'b0, 6'd1);
      rd_chk(`DTT_OFS_LATCH_LO, 32'h0);
      pulse_hw(3);
      rd_chk(`DTT_OFS_LATCH_LO, 32'h0);
      pulse_hw(2);
      pulse_hw(2);
      rd_chk(`DTT_OFS_LATCH_LO, 32'h4);
      rd_chk(`DTT_OFS_MISS_LO, 32'h4);
      wr(`DTT_OFS_MISS_LO, 32'h4);
      wr(`DTT_OFS_ENABLE_LO, 32'h6);
      tr_chk(1'b0, 6'd2);
      rd_chk(`DTT_OFS_LATCH_LO, 32'h0);
    end
  endtask
  // slow acceptance keeps channel 5 pending behind channel 4
  task s_manual;
    begin
      wr(`DTT_OFS_SET_LO, 32'h0);
      rd_chk(`DTT_OFS_SET_LO, 32'h0);
      tc_delay <= 4'd8;
      wr(`DTT_OFS_SET_LO, 32'h10);
      wr(`DTT_OFS_SET_LO, 32'h20);
      wr(`DTT_OFS_SET_LO, 32'h20);
      rd_chk(`DTT_OFS_MISS_LO, 32'h20);
      tr_chk(1'b0, 6'd4);
      tr_chk(1'b0, 6'd5);
      wr(`DTT_OFS_MISS_LO, 32'h20);
      wr(`DTT_OFS_SET_HI, 32'h2);
      tr_chk(1'b0, 6'd33);
      tc_delay <= 4'd0;
    end
  endtask
  task s_null_chain;
    begin
      @(posedge CLK_SYS) PSET_NULL <= 64'h40;
      wr(`DTT_OFS_SET_LO, 32'h40);
      repeat (8) @(posedge CLK_SYS);
      chk(tc_count, exp_n);
      rd_chk(`DTT_OFS_MISS_LO, 32'h40);
      rd_chk(`DTT_OFS_SET_LO, 32'h0);
      @(posedge CLK_SYS) begin PSET_NULL <= 64'h0; CMPL_CODE <= 6'd40; CMPL_STB <= 1'b1; end
      @(posedge CLK_SYS) CMPL_STB <= 1'b0;
      tr_chk(1'b0, 6'd40);
    end
  endtask
  task s_quick;
    begin
      wr(`DTT_OFS_QMAP_BASE, 32'h10);
      wr(`DTT_OFS_QMAP_BASE + 8'h04, 32'h20);
      trig_q(1'b0, 9'h010);
      rd_chk(`DTT_OFS_QEVT, 32'h0);
      chk(tc_count, exp_n);
      wr(`DTT_OFS_QEN, 32'h3);
      trig_q(1'b0, 9'h010);
      tr_chk(1'b1, 6'd0);
      trig_q(1'b1, 9'h020);
      tr_chk(1'b1, 6'd1);
    end
  endtask
  initial begin
    repeat (3) @(posedge CLK_SYS);
    ARST_N <= 1'b1;
    s_hw;
    s_manual;
    s_null_chain;
    s_quick;
    rd_chk(8'hfc, 32'h0);
    give_verdict;
  end
endmodule // dtt_trigger_test
